// *** rtl/adc_backend_defs.svh ***
`ifndef ADC_BACKEND_DEFS_SVH
`define ADC_BACKEND_DEFS_SVH

// Core cycles per sample clock period
`define CYC_PER_SAMPLE 4
// Pipeline shape
`define NUM_STAGES 8
`define STAGE_W 2
`define ALIGN_W 18
`define DATA_W 10
// Sample clocks from capture to output load
`define LATENCY_CYC 6
`define LAT_CNT_W 3
`define FIFO_DEPTH 16
// Full-scale and reset values
`define CODE_MAX 10'h3ff
`define DATA_RST 10'h000

`endif

// *** rtl/adc_backend_pkg.sv ***
package adc_backend_pkg;
`include "adc_backend_defs.svh"

   // Partially assembled word travelling down the delay line
   typedef struct packed {
      logic vld;
      logic [`ALIGN_W-1:0] bits;
   } slot_s;

   typedef struct packed {
      slot_s [`NUM_STAGES:0] slot;
      logic corr_vld;
      logic [`DATA_W-1:0] corr;
      logic [`LAT_CNT_W-1:0] lat_cnt;
      logic [`DATA_W-1:0] data;
      logic data_vld;
      logic ovf;
   } core_state_s;

endpackage : adc_backend_pkg

// *** rtl/two_phase_gen.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "adc_backend_defs.svh"
module two_phase_gen #(
   parameter int CYC_PER_SAMPLE = `CYC_PER_SAMPLE
) (
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   output logic phi1_out,
   output logic phi2_out,
   output logic phi1_end_out,
   output logic phi2_end_out
);
   localparam int HALF = CYC_PER_SAMPLE / 2;

   typedef struct packed {
      logic [7:0] cnt;
      logic phi1;
      logic phi2;
      logic phi1_end;
      logic phi2_end;
   } phase_state_s;

   phase_state_s st_ff;
   phase_state_s nxt_st;

   initial begin
      if (CYC_PER_SAMPLE < 4 || CYC_PER_SAMPLE % 2 != 0 || CYC_PER_SAMPLE > 256) begin
         $error("two_phase_gen: CYC_PER_SAMPLE must be even, 4..256");
      end
   end

   // Gap cycle after each phase keeps the two phases apart [RULE1]
   always_comb begin
      nxt_st = st_ff;
      nxt_st.cnt = (st_ff.cnt == 8'(CYC_PER_SAMPLE - 1)) ? 8'h00 : st_ff.cnt + 8'h01;
      nxt_st.phi1 = (nxt_st.cnt < 8'(HALF - 1));
      nxt_st.phi2 = (nxt_st.cnt >= 8'(HALF)) && (nxt_st.cnt < 8'(CYC_PER_SAMPLE - 1));
      nxt_st.phi1_end = (nxt_st.cnt == 8'(HALF - 2));
      nxt_st.phi2_end = (nxt_st.cnt == 8'(CYC_PER_SAMPLE - 2));
   end

   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         st_ff <= '{cnt: 8'hff, default: 1'b0};
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign phi1_out = st_ff.phi1;
   assign phi2_out = st_ff.phi2;
   assign phi1_end_out = st_ff.phi1_end;
   assign phi2_end_out = st_ff.phi2_end;

   no_overlap_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in) // [RULE1]
      !(phi1_out && phi2_out))
      else $error("phases overlap");
endmodule : two_phase_gen
`default_nettype wire

// *** rtl/sample_fifo.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "adc_backend_defs.svh"
module sample_fifo #(
   parameter int WIDTH = `DATA_W,
   parameter int DEPTH = `FIFO_DEPTH
) (
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   input wire logic in_valid_in,
   output logic in_ready_out,
   input wire logic [WIDTH-1:0] in_data_in,
   output logic out_valid_out,
   input wire logic out_ready_in,
   output logic [WIDTH-1:0] out_data_out
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] rd;
      logic [AW-1:0] wr;
      logic [AW:0] cnt;
   } fifo_state_s;

   fifo_state_s st_ff;
   fifo_state_s nxt_st;
   logic push;
   logic pop;

   initial begin
      if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin
         $error("sample_fifo: DEPTH must be a power of two >= 2");
      end
   end

   assign in_ready_out = (st_ff.cnt != (AW + 1)'(DEPTH));
   assign out_valid_out = (st_ff.cnt != '0);
   assign out_data_out = st_ff.mem[st_ff.rd];
   assign push = in_valid_in && in_ready_out;
   assign pop = out_valid_out && out_ready_in;

   always_comb begin
      nxt_st = st_ff;
      if (push) begin
         nxt_st.mem[st_ff.wr] = in_data_in;
         nxt_st.wr = st_ff.wr + 1'b1;
      end
      if (pop) begin
         nxt_st.rd = st_ff.rd + 1'b1;
      end
      nxt_st.cnt = st_ff.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
   end

   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end
endmodule : sample_fifo
`default_nettype wire

// *** rtl/adc_backend.sv ***
// Operation
// RULE1 - Two non-overlapping phases are derived from the master sample clock.
// RULE2 - A sample is taken as the first phase ends.
// RULE3 - Eight two-bit stages feed the line, then a two-bit flash stage.
// RULE4 - Each stage samples in one phase and amplifies in the other.
// RULE5 - Successive stages run on opposite phases, half a sample apart.
// RULE6 - Each stage's two-bit code carries one redundant bit for correction.
// RULE7 - A sample-clocked delay line aligns all stage codes into eighteen bits. Here the line shifts on every half tick, twice per sample clock.
// RULE8 - Correction uses the redundant bits to yield one ten-bit result.
// RULE9 - Result appears after the sixth sample clock following capture.
// RULE10 - After the latency, one new result appears every sample clock.
// RULE11 - Every output word is offset binary.
// RULE12 - Most negative is all zeros, most positive all ones, midpoint splits.
// RULE13 - Output register updates once per sample clock and holds between.
`timescale 1ns/1ps
`default_nettype none
`include "adc_backend_defs.svh"
module adc_backend
   import adc_backend_pkg::*;
#(
   parameter int CYC_PER_SAMPLE = `CYC_PER_SAMPLE,
   parameter int LATENCY = `LATENCY_CYC,
   parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   // Stage k code on bits [2k+1:2k]; stage 8 is the flash stage
   input wire logic [`ALIGN_W-1:0] stage_bits_in,
   output logic phi1_out,
   output logic phi2_out,
   // Bit 9 is channel_output_msb, bit 0 channel_output_lsb
   output logic [`DATA_W-1:0] sample_word_out,
   output logic word_valid_out,
   output logic overflow_out
);
   localparam int NS = `NUM_STAGES;

   core_state_s st_ff;
   core_state_s nxt_st;
   logic phi1_end;
   logic phi2_end;
   logic half_tick;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic fifo_pop;
   logic [`DATA_W-1:0] fifo_out_data;
   logic primed;

   initial begin
      if (LATENCY < 6 || LATENCY > (1 << `LAT_CNT_W) - 1) begin
         $error("adc_backend: LATENCY out of range 6..7");
      end
      if (FIFO_DEPTH < LATENCY) begin
         $error("adc_backend: FIFO_DEPTH too small for LATENCY");
      end
   end

   // Weighted sum of overlapping stage codes; the redundant bit of each
   // stage lands on the next stage's MSB so carries fix stage errors.
   function automatic logic [`DATA_W-1:0] correct(input logic [`ALIGN_W-1:0] w);
      logic [`DATA_W+1:0] sum;
      sum = '0;
      for (int k = 0; k < NS; k++) begin
         sum = sum + ((`DATA_W + 2)'(w[2*k +: 2]) << (NS - k)); // [RULE6] [RULE8]
      end
      sum = sum + (`DATA_W + 2)'(w[2*NS +: 2]);
      // Illegal stage code 3 can overrun full scale; clamp to all ones
      if (sum > (`DATA_W + 2)'(`CODE_MAX)) begin
         correct = `CODE_MAX; // [RULE12]
      end else begin
         correct = sum[`DATA_W-1:0]; // [RULE11]
      end
   endfunction : correct

   two_phase_gen #(
      .CYC_PER_SAMPLE(CYC_PER_SAMPLE)
   ) u_phase (
      .core_clk_in(core_clk_in),
      .rst_n_in(rst_n_in),
      .phi1_out(phi1_out),
      .phi2_out(phi2_out),
      .phi1_end_out(phi1_end),
      .phi2_end_out(phi2_end)
   );

   // Stage results settle at the end of each phase, alternating [RULE4] [RULE5]
   assign half_tick = phi1_end || phi2_end;
   assign primed = (st_ff.lat_cnt == `LAT_CNT_W'(LATENCY));
   assign fifo_pop = phi1_end && primed;

   sample_fifo #(
      .WIDTH(`DATA_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .core_clk_in(core_clk_in),
      .rst_n_in(rst_n_in),
      .in_valid_in(st_ff.corr_vld),
      .in_ready_out(fifo_in_ready),
      .in_data_in(st_ff.corr),
      .out_valid_out(fifo_out_valid),
      .out_ready_in(fifo_pop),
      .out_data_out(fifo_out_data)
   );

   always_comb begin
      nxt_st = st_ff;
      nxt_st.corr_vld = 1'b0;
      if (half_tick) begin
         // New sample enters at the end of the first phase [RULE2]
         nxt_st.slot[0].vld = phi1_end;
         nxt_st.slot[0].bits = '0;
         // Stage j-1 result joins the word that reached slot j [RULE3] [RULE7]
         for (int j = 1; j <= NS; j++) begin
            nxt_st.slot[j] = st_ff.slot[j-1];
            nxt_st.slot[j].bits[2*(j-1) +: 2] = stage_bits_in[2*(j-1) +: 2];
         end
         // Flash stage completes the eighteen-bit word [RULE7]
         if (st_ff.slot[NS].vld) begin
            nxt_st.corr_vld = 1'b1;
            nxt_st.corr = correct({stage_bits_in[2*NS +: 2],
                                   st_ff.slot[NS].bits[2*NS-1:0]}); // [RULE8]
         end
      end
      // Count sample clocks since the first capture [RULE9]
      if (phi1_end && !primed) begin
         nxt_st.lat_cnt = st_ff.lat_cnt + 1'b1;
      end
      // Load only on a sample clock, hold otherwise [RULE10] [RULE13]
      if (fifo_pop) begin
         nxt_st.data = fifo_out_data;
         nxt_st.data_vld = fifo_out_valid;
      end
      // Full buffer cannot stall the analog pipeline; flag lost words
      if (st_ff.corr_vld && !fifo_in_ready) begin
         nxt_st.ovf = 1'b1;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         st_ff <= '{data: `DATA_RST, default: '0};
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign sample_word_out = st_ff.data;
   assign word_valid_out = st_ff.data_vld;
   assign overflow_out = st_ff.ovf;

   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (!rst_n_in);

   // Capture marks sit on the last cycle of phi1
   sample_edge_a: assert property (phi1_end |-> phi1_out ##1 !phi1_out) // [RULE2]
      else $error("capture not at end of phi1");

   // phi2 follows phi1 with a gap, never touching it
   phase_gap_a: assert property ($fell(phi1_out) |-> !phi2_out) // [RULE1]
      else $error("phi2 starts without gap");

   // Half ticks alternate between the two phases
   half_alt_a: assert property (phi1_end |=> !phi1_end [*1] ##[0:2] phi2_end) // [RULE5]
      else $error("phases do not alternate");

   // A captured word is complete after nine half periods
   align_time_a: assert property (phi1_end && primed ##1 1 // [RULE7]
      |-> ##17 st_ff.slot[NS].vld)
      else $error("aligned word late");

   // Correction follows the last slot by one cycle
   corr_follow_a: assert property (half_tick && st_ff.slot[NS].vld |=> st_ff.corr_vld) // [RULE8]
      else $error("correction missing");

   // Output changes only on a sample clock
   hold_stable_a: assert property (!$past(fifo_pop) |-> $stable(sample_word_out)) // [RULE13]
      else $error("output changed between sample clocks");

   // Once primed, a word is always ready at each sample clock
   steady_rate_a: assert property (fifo_pop |-> fifo_out_valid) // [RULE10]
      else $error("no word at sample clock");

   // Latency counter reaches its mark after six captures
   latency_cnt_a: assert property (phi1_end && st_ff.lat_cnt == `LAT_CNT_W'(LATENCY - 1)
      |=> primed) // [RULE9]
      else $error("latency count wrong");

   // Stage codes of two with a flash code of three give full scale
   full_scale_a: assert property (half_tick && st_ff.slot[NS].vld
      && stage_bits_in[2*NS +: 2] == 2'h3 && st_ff.slot[NS].bits[2*NS-1:0] == 16'haaaa
      |=> st_ff.corr == `CODE_MAX) // [RULE12]
      else $error("full scale code wrong");

   // All-zero codes give all zeros
   zero_scale_a: assert property (half_tick && st_ff.slot[NS].vld
      && stage_bits_in == '0 && st_ff.slot[NS].bits == '0
      |=> st_ff.corr == '0) // [RULE11]
      else $error("zero code wrong");

   // Buffer never overflows in steady operation
   no_overflow_a: assert property (!overflow_out) // [RULE10]
      else $error("sample buffer overflow");
endmodule : adc_backend
`default_nettype wire

// *** bench/word_capture.sv ***
`timescale 1ns/1ps
`default_nettype none
module word_capture (
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   input wire logic phi1_in,
   input wire logic phi2_in,
   input wire logic [9:0] word_in,
   output logic [9:0] cap_word_out,
   output logic hold_err_out
);
   logic [9:0] last_ff;
   logic phi1_ff;
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         cap_word_out <= 10'h000;
         hold_err_out <= 1'b0;
         last_ff <= 10'h000;
         phi1_ff <= 1'b0;
      end else begin
         // Word may move only right after a sampling phase
         if (word_in != last_ff && !phi1_ff) hold_err_out <= 1'b1;
         // Capture mid-way through the word's stand
         if (phi2_in) cap_word_out <= word_in;
         last_ff <= word_in;
         phi1_ff <= phi1_in;
      end
   end
endmodule : word_capture
`default_nettype wire

// *** bench/pipeline_adc_digital_backend_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module pipeline_adc_digital_backend_tb_top;
   typedef struct packed {
      logic [17:0] codes;
      logic [9:0] res;
   } row_s;
   localparam int NR = 7;
   localparam row_s ROWS [NR] = '{
      '{18'h00000, 10'h000}, '{18'h10000, 10'h001}, '{18'h00002, 10'h200},
      '{18'h3aaa8, 10'h1ff}, '{18'h00009, 10'h200}, '{18'h3aaaa, 10'h3ff},
      '{18'h2aaaa, 10'h3fe}};
   logic core_clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic [17:0] stage_bits_in = 18'h00000;
   logic phi1_out, phi2_out, word_valid_out, overflow_out, hold_err;
   logic [9:0] sample_word_out, cap_word;
   int mismatches = 0;
   int checks = 0;
   int i;

   adc_backend u_dut (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
      .stage_bits_in(stage_bits_in), .phi1_out(phi1_out), .phi2_out(phi2_out),
      .sample_word_out(sample_word_out), .word_valid_out(word_valid_out),
      .overflow_out(overflow_out));
   word_capture u_cap (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
      .phi1_in(phi1_out), .phi2_in(phi2_out), .word_in(sample_word_out),
      .cap_word_out(cap_word), .hold_err_out(hold_err));

   always #2 core_clk_in = ~core_clk_in;

   task automatic close_out;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : close_out

   task automatic chk_w(input string nm, input logic [9:0] e, input logic [9:0] s);
      checks++;
      if (s !== e) begin
         mismatches++;
         $display("MISMATCH %s exp %h seen %h", nm, e, s);
      end
   endtask : chk_w

   task automatic chk_b(input string nm, input logic e, input logic s);
      checks++;
      if (s !== e) begin
         mismatches++;
         $display("MISMATCH %s exp %b seen %b", nm, e, s);
      end
   endtask : chk_b

   task automatic tick;
      @(posedge core_clk_in);
      #1;
   endtask : tick

   task automatic sync;
      for (int n = 0; n < 8 && phi1_out !== 1'b1; n++) tick();
      chk_b("phi1_start", 1'b1, phi1_out);
      if (phi1_out !== 1'b1) close_out();
   endtask : sync

   // Half tick t: stage k carries sample (t-k-1)/2; other cycles toggle
   task automatic stream(input int ns);
      int t, m, gap;
      logic [17:0] b;
      t = 0;
      gap = 0;
      for (int c = 0; c < 8 * ns + 64 && t < 2 * ns + 16; c++) begin
         if (phi1_out | phi2_out) begin
            b = '0;
            for (int k = 0; k < 9; k++) begin
               m = t - k - 1;
               if (m >= 0 && m % 2 == 0 && m / 2 < ns)
                  b[2*k+:2] = ROWS[(m/2)%NR].codes[2*k+:2];
            end
            stage_bits_in = b;
            if (t > 0) chk_w("half_gap", 10'h002, gap[9:0]);
            chk_b("overlap", 1'b0, phi1_out & phi2_out);
            m = t / 2 - 7;
            if (phi1_out && m >= 2 && m < ns)
               chk_w("word", ROWS[m%NR].res, cap_word);
            if (t == 12) chk_b("valid_early", 1'b0, word_valid_out);
            if (t == 14) chk_b("valid_set", 1'b1, word_valid_out);
            t++;
            gap = 0;
         end else begin
            stage_bits_in = ~stage_bits_in;
         end
         tick();
         gap++;
      end
      if (t < 2 * ns + 16) begin
         mismatches++;
         close_out();
      end
   endtask : stream

   initial begin
      repeat (5) @(posedge core_clk_in);
      #1 rst_n_in = 1'b1;
      sync();
      stream(14);
      $display("test stream done");
      rst_n_in = 1'b0;
      tick();
      tick();
      chk_w("word_rst", 10'h000, sample_word_out);
      chk_b("valid_rst", 1'b0, word_valid_out);
      chk_b("phi1_rst", 1'b0, phi1_out);
      rst_n_in = 1'b1;
      sync();
      stream(9);
      chk_b("overflow", 1'b0, overflow_out);
      chk_b("hold", 1'b0, hold_err);
      $display("test reset done");
      // Buffer keeps one word per sample clock through the top
      for (i = 0; i < 16; i++) begin
         sync();
         chk_b("fifo_valid", 1'b1, word_valid_out);
         tick();
      end
      chk_w("fifo_count", 10'h010, i[9:0]);
      chk_b("fifo_ovf", 1'b0, overflow_out);
      $display("test fifo done");
      close_out();
   end
endmodule : pipeline_adc_digital_backend_tb_top
`default_nettype wire
